// ==== core/rol_output_logic.sv ====
/*
 * reset and overtemperature output logic of a system monitor: drives the
 * active-low overtemperature alarm and the active-low system reset.
 * assumes the threshold flags arrive already compared and synchronous to clk,
 * and that registers are written through a simple 8-bit strobed port.
 */
// What this block does
// - remote 1 short flag drives alarm, bit 3
// - diode faults latch alarm; clear-register write clears
// - bit 4: remote 1 open flag latches alarm
// - bit 5: remote 2 short flag latches alarm
// - bit 6: remote 2 open; bit 7 reserved
// - mode 000: reset only at boot timeout
// - mode 001: selected undervoltage asserts reset
// - mode 010: selected overvoltage asserts reset
// - mode 011: selected under or overvoltage asserts reset
// - mode 100: undervoltage or internal overtemp resets
// - mode 101: under/overvoltage or internal overtemp resets
// - timeout field picks 25us up to 2560ms
// - each mask bit enables one voltage input
module rol_output_logic
    import rol_pkg::*;
#(
    parameter rol_cnt_t TOUT1_CYCLES = rol_cnt_t'(TOUT1_CYC),
    parameter rol_cnt_t TOUT2_CYCLES = rol_cnt_t'(TOUT2_CYC),
    parameter rol_cnt_t TOUT3_CYCLES = rol_cnt_t'(TOUT3_CYC),
    parameter rol_cnt_t TOUT4_CYCLES = rol_cnt_t'(TOUT4_CYC),
    parameter rol_cnt_t TOUT5_CYCLES = rol_cnt_t'(TOUT5_CYC),
    parameter rol_cnt_t TOUT6_CYCLES = rol_cnt_t'(TOUT6_CYC),
    parameter rol_cnt_t TOUT7_CYCLES = rol_cnt_t'(TOUT7_CYC)
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    // register port
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic [7:0]      regRdData,
    // reset input select mask, held elsewhere
    input  wire logic [7:0] reset_input_select_mask,
    // comparator flags of the monitored voltage inputs
    input  wire logic [7:0] priUnderVolt,
    input  wire logic [7:0] priOverVolt,
    // temperature flags
    input  wire logic       intPriOverTemp,
    input  wire logic       rem1PriOverTemp,
    input  wire logic       rem2PriOverTemp,
    input  wire logic       rem1DiodeShort,
    input  wire logic       rem1DiodeOpen,
    input  wire logic       rem2DiodeShort,
    input  wire logic       rem2DiodeOpen,
    // outputs
    output logic            overtemp_alarm_n,
    output logic            systemReset_n
);

    // =====================================================================
    // timeout lookup
    // =====================================================================
    function automatic rol_cnt_t toutCycles(input logic [2:0] sel);
        rol_cnt_t c;
        c = rol_cnt_t'(TOUT0_CYC);
        unique case (sel)
            3'h0: c = rol_cnt_t'(TOUT0_CYC);
            3'h1: c = TOUT1_CYCLES;
            3'h2: c = TOUT2_CYCLES;
            3'h3: c = TOUT3_CYCLES;
            3'h4: c = TOUT4_CYCLES;
            3'h5: c = TOUT5_CYCLES;
            3'h6: c = TOUT6_CYCLES;
            3'h7: c = TOUT7_CYCLES;
        endcase
        return c;
    endfunction : toutCycles

    logic [7:0]     otSrcSel_reg;
    logic [7:0]     otSrcSel_next;
    logic [7:0]     rstCfg_reg;
    logic [7:0]     rstCfg_next;
    logic [3:0]     diodeLatch_reg;
    logic [3:0]     diodeLatch_next;
    logic [7:0]     rdData_reg;
    logic [7:0]     rdData_next;
    logic           alarmN_reg;
    logic           alarmN_next;
    logic           resetN_reg;
    logic           resetN_next;

    logic           clearWrite;
    logic [3:0]     diodeHit;
    logic           liveOverTemp;
    logic [7:0]     selUv;
    logic [7:0]     selOv;
    logic           resetCond;
    logic [2:0]     rstMode;
    logic [2:0]     toutSel;

    rol_hold_if     hold ();

    // =====================================================================
    // register writes; reserved bits are kept at zero
    // =====================================================================
    always_comb begin
        otSrcSel_next = otSrcSel_reg;
        rstCfg_next   = rstCfg_reg;
        if (regWrEn && regAddr == OFS_OT_SRC_SEL) begin
            otSrcSel_next = regWrData & OT_SRC_WMASK;
        end
        if (regWrEn && regAddr == OFS_RST_CFG) begin
            rstCfg_next = regWrData & RST_CFG_WMASK;
        end
    end

    // any write to the clear register counts, the data is ignored
    assign clearWrite = regWrEn && (regAddr == OFS_DIODE_LATCH);

    // =====================================================================
    // overtemperature sources
    // =====================================================================
    // diode fault hits, in latch bit order r1 short, r1 open, r2 short, r2 open
    assign diodeHit[0] = otSrcSel_reg[OT_R1_SHORT] & rem1DiodeShort;
    assign diodeHit[1] = otSrcSel_reg[OT_R1_OPEN]  & rem1DiodeOpen;
    assign diodeHit[2] = otSrcSel_reg[OT_R2_SHORT] & rem2DiodeShort;
    assign diodeHit[3] = otSrcSel_reg[OT_R2_OPEN]  & rem2DiodeOpen;

    // primary overtemperature thresholds follow the flags without latching
    assign liveOverTemp = (otSrcSel_reg[OT_INT_PRI] & intPriOverTemp)
                        | (otSrcSel_reg[OT_R1_PRI]  & rem1PriOverTemp)
                        | (otSrcSel_reg[OT_R2_PRI]  & rem2PriOverTemp);

    // latch next: a fault in the clearing cycle wins over the clear
    always_comb begin
        diodeLatch_next = diodeLatch_reg;
        if (clearWrite) begin
            diodeLatch_next = '0;
        end
        diodeLatch_next = diodeLatch_next | diodeHit;
        alarmN_next = !(liveOverTemp || (|diodeLatch_next));
    end

    // =====================================================================
    // reset condition selection
    // =====================================================================
    assign rstMode = rstCfg_reg[RC_MODE_LSB +: 3];
    assign toutSel = rstCfg_reg[RC_TOUT_LSB +: 3];
    assign selUv   = priUnderVolt & reset_input_select_mask;
    assign selOv   = priOverVolt  & reset_input_select_mask;

    // codes 110 and 111 are not defined yet; they behave as no dependency
    always_comb begin
        resetCond = 1'b0;
        unique case (rol_rst_mode_e'(rstMode))
            RM_NONE:     resetCond = 1'b0;
            RM_UV:       resetCond = |selUv;
            RM_OV:       resetCond = |selOv;
            RM_UV_OV:    resetCond = |(selUv | selOv);
            RM_UV_OT:    resetCond = (|selUv) | intPriOverTemp;
            RM_UV_OV_OT: resetCond = (|(selUv | selOv)) | intPriOverTemp;
            RM_RSV6:     resetCond = 1'b0;
            RM_RSV7:     resetCond = 1'b0;
        endcase
    end

    assign hold.resetCond  = resetCond;
    assign hold.holdCycles = toutCycles(toutSel);

    // hold timer drives the reset; output flop adds one cycle of latency
    rol_hold_timer #(
        .BOOT_CYCLES (rol_cnt_t'(TOUT0_CYC))
    ) u_hold (
        .clk   (clk),
        .rst_b (rst_b),
        .hold  (hold.timer)
    );

    assign resetN_next = !hold.holdActive;

    // =====================================================================
    // read data; latch register shows which diode faults are held
    // =====================================================================
    always_comb begin
        rdData_next = rdData_reg;
        if (regRdEn) begin
            unique case (regAddr)
                OFS_OT_SRC_SEL:  rdData_next = otSrcSel_reg;
                OFS_RST_CFG:     rdData_next = rstCfg_reg;
                OFS_DIODE_LATCH: rdData_next = {4'h0, diodeLatch_reg};
                default:         rdData_next = 8'h00;
            endcase
        end
    end

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            otSrcSel_reg   <= OT_SRC_SEL_RST;
            rstCfg_reg     <= RST_CFG_RST;
            diodeLatch_reg <= 4'h0;
            rdData_reg     <= 8'h00;
            alarmN_reg     <= 1'b1;
            resetN_reg     <= 1'b0;
        end else begin
            otSrcSel_reg   <= otSrcSel_next;
            rstCfg_reg     <= rstCfg_next;
            diodeLatch_reg <= diodeLatch_next;
            rdData_reg     <= rdData_next;
            alarmN_reg     <= alarmN_next;
            resetN_reg     <= resetN_next;
        end
    end

    assign overtemp_alarm_n = alarmN_reg;
    assign systemReset_n    = resetN_reg;
    assign regRdData        = rdData_reg;

endmodule : rol_output_logic

// ==== core/rol_pkg.sv ====
/*
 * constants for the reset and overtemperature output logic: register offsets,
 * field positions, reset values and reset timeout counts.
 * assumes a 20 MHz core clock; all timeouts are whole multiples of its period.
 */
package rol_pkg;

    // =====================================================================
    // clock and counter width
    // =====================================================================
    localparam int unsigned CLK_MHZ = 20;
    localparam int unsigned CNT_W   = 26;
    typedef logic [CNT_W-1:0] rol_cnt_t;

    // =====================================================================
    // register offsets (8-bit register space)
    // =====================================================================
    localparam logic [7:0] OFS_OT_SRC_SEL   = 8'h1F;
    localparam logic [7:0] OFS_RST_CFG      = 8'h20;
    localparam logic [7:0] OFS_DIODE_LATCH  = 8'h50;

    // reset values of the configuration registers
    localparam logic [7:0] OT_SRC_SEL_RST   = 8'h00;
    localparam logic [7:0] RST_CFG_RST      = 8'h00;

    // =====================================================================
    // overtemp source select fields
    // =====================================================================
    localparam int unsigned OT_INT_PRI      = 0;
    localparam int unsigned OT_R1_PRI       = 1;
    localparam int unsigned OT_R2_PRI       = 2;
    localparam int unsigned OT_R1_SHORT     = 3;
    localparam int unsigned OT_R1_OPEN      = 4;
    localparam int unsigned OT_R2_SHORT     = 5;
    localparam int unsigned OT_R2_OPEN      = 6;
    localparam logic [7:0]  OT_SRC_WMASK    = 8'h7F;   // bit 7 reserved

    // =====================================================================
    // reset configuration fields
    // =====================================================================
    localparam int unsigned RC_MODE_LSB     = 0;
    localparam int unsigned RC_TOUT_LSB     = 3;
    localparam logic [7:0]  RST_CFG_WMASK   = 8'h3F;   // bits 7:6 reserved

    typedef enum logic [2:0] {
        RM_NONE     = 3'h0,
        RM_UV       = 3'h1,
        RM_OV       = 3'h2,
        RM_UV_OV    = 3'h3,
        RM_UV_OT    = 3'h4,
        RM_UV_OV_OT = 3'h5,
        RM_RSV6     = 3'h6,
        RM_RSV7     = 3'h7
    } rol_rst_mode_e;

    // =====================================================================
    // reset timeouts, in microseconds, and their cycle counts
    // =====================================================================
    localparam int unsigned TOUT0_US = 25;
    localparam int unsigned TOUT1_US = 2500;
    localparam int unsigned TOUT2_US = 10000;
    localparam int unsigned TOUT3_US = 40000;
    localparam int unsigned TOUT4_US = 160000;
    localparam int unsigned TOUT5_US = 640000;
    localparam int unsigned TOUT6_US = 1280000;
    localparam int unsigned TOUT7_US = 2560000;

    localparam int unsigned TOUT0_CYC = TOUT0_US * CLK_MHZ;
    localparam int unsigned TOUT1_CYC = TOUT1_US * CLK_MHZ;
    localparam int unsigned TOUT2_CYC = TOUT2_US * CLK_MHZ;
    localparam int unsigned TOUT3_CYC = TOUT3_US * CLK_MHZ;
    localparam int unsigned TOUT4_CYC = TOUT4_US * CLK_MHZ;
    localparam int unsigned TOUT5_CYC = TOUT5_US * CLK_MHZ;
    localparam int unsigned TOUT6_CYC = TOUT6_US * CLK_MHZ;
    localparam int unsigned TOUT7_CYC = TOUT7_US * CLK_MHZ;

endpackage : rol_pkg

// ==== core/rol_hold_if.sv ====
/*
 * carrier between the output logic and its reset hold timer.
 * assumes both ends share one clock; no crossing inside.
 */
interface rol_hold_if;
    import rol_pkg::*;

    logic           resetCond;      // some enabled reset condition is present
    rol_cnt_t       holdCycles;     // timeout length to reload on a condition
    logic           holdActive;     // reset still asserted (condition or hold)

    modport ctrl  (output resetCond, output holdCycles, input  holdActive);
    modport timer (input  resetCond, input  holdCycles, output holdActive);
endinterface : rol_hold_if

// ==== core/rol_hold_timer.sv ====
/*
 * reset hold timer: keeps reset asserted while a condition is present and for
 * the chosen timeout after it clears.
 * assumes resetCond is synchronous to clk; rst_b is the boot reset.
 */
module rol_hold_timer
    import rol_pkg::*;
#(
    parameter rol_cnt_t BOOT_CYCLES = rol_cnt_t'(TOUT0_CYC)
) (
    input  wire logic   clk,
    input  wire logic   rst_b,
    rol_hold_if.timer   hold
);

    typedef enum logic [1:0] {
        HS_ASSERT  = 2'b01,
        HS_RELEASE = 2'b10
    } rol_hold_state_e;

    rol_hold_state_e    state_reg;
    rol_hold_state_e    state_next;
    rol_cnt_t           count_reg;
    rol_cnt_t           count_next;

    // =====================================================================
    // next state: a condition reloads the count, so recurrence restarts it
    // =====================================================================
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            HS_ASSERT: begin
                if (hold.resetCond) begin
                    count_next = hold.holdCycles;
                end else if (count_reg > rol_cnt_t'(1)) begin
                    count_next = count_reg - rol_cnt_t'(1);
                end else begin
                    count_next = '0;
                    state_next = HS_RELEASE;
                end
            end
            HS_RELEASE: begin
                if (hold.resetCond) begin
                    count_next = hold.holdCycles;
                    state_next = HS_ASSERT;
                end
            end
        endcase
    end

    // =====================================================================
    // registers; boot starts in assert with the boot timeout loaded
    // =====================================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= HS_ASSERT;
            count_reg <= BOOT_CYCLES;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    assign hold.holdActive = (state_reg == HS_ASSERT);

endmodule : rol_hold_timer

// ==== sim/rol_output_logic_chk.sv ====
/* checker on the output logic ports: alarm latch, reset causes and hold.
   assumes it is bound onto rol_output_logic, one clock, rst_b sync low. */
module rol_output_logic_chk
    import rol_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       regWrEn,
    input wire logic       regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic [7:0] reset_input_select_mask,
    input wire logic [7:0] priUnderVolt,
    input wire logic [7:0] priOverVolt,
    input wire logic       intPriOverTemp,
    input wire logic       rem1PriOverTemp,
    input wire logic       rem2PriOverTemp,
    input wire logic       rem1DiodeShort,
    input wire logic       rem1DiodeOpen,
    input wire logic       rem2DiodeShort,
    input wire logic       rem2DiodeOpen,
    input wire logic       overtemp_alarm_n,
    input wire logic       systemReset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // shadow state
    // ====================
    logic [7:0] selReg;
    logic [7:0] cfgReg;
    logic       cond;
    logic       quiet;
    logic       diode;
    logic       wrClr;

    // shadows track writes so the checker knows which sources are enabled
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            selReg <= OT_SRC_SEL_RST;
            cfgReg <= RST_CFG_RST;
        end else if (regWrEn && regAddr == OFS_OT_SRC_SEL) begin
            selReg <= regWrData & OT_SRC_WMASK;
        end else if (regWrEn && regAddr == OFS_RST_CFG) begin
            cfgReg <= regWrData & RST_CFG_WMASK;
        end
    end

    // reset cause for the chosen mode; codes 110 and 111 have none
    assign cond = (cfgReg[2:0] inside {RM_UV, RM_UV_OV, RM_UV_OT, RM_UV_OV_OT}
                   && |(priUnderVolt & reset_input_select_mask))
               || (cfgReg[2:0] inside {RM_OV, RM_UV_OV, RM_UV_OV_OT}
                   && |(priOverVolt & reset_input_select_mask))
               || (cfgReg[2:0] inside {RM_UV_OT, RM_UV_OV_OT} && intPriOverTemp);
    assign quiet = cfgReg[2:0] inside {RM_NONE, RM_RSV6, RM_RSV7};
    assign diode = |(selReg[6:3] & {rem2DiodeOpen, rem2DiodeShort, rem1DiodeOpen, rem1DiodeShort});
    assign wrClr = regWrEn && regAddr == OFS_DIODE_LATCH;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_r1_short; selReg[OT_R1_SHORT] && rem1DiodeShort |=> !overtemp_alarm_n; endproperty
    a_r1_short: assert property (p_r1_short) else $error("no alarm on r1 short");
    property p_r1_open; selReg[OT_R1_OPEN] && rem1DiodeOpen ##1 (!wrClr)[*3] |-> !overtemp_alarm_n;
    endproperty
    a_r1_open: assert property (p_r1_open) else $error("r1 open not latched");
    property p_r2_short; selReg[OT_R2_SHORT] && rem2DiodeShort |=> !overtemp_alarm_n; endproperty
    a_r2_short: assert property (p_r2_short) else $error("no alarm on r2 short");
    property p_r2_open; selReg[OT_R2_OPEN] && rem2DiodeOpen |=> !overtemp_alarm_n; endproperty
    a_r2_open: assert property (p_r2_open) else $error("no alarm on r2 open");
    property p_clear; wrClr && !diode && selReg[2:0] == 3'h0 |=> overtemp_alarm_n; endproperty
    a_clear: assert property (p_clear) else $error("latch not cleared");
    property p_rst_cond; cond |-> ##2 !systemReset_n; endproperty
    a_rst_cond: assert property (p_rst_cond) else $error("reset missed");
    property p_rst_temp;
        cfgReg[2:0] inside {RM_UV_OT, RM_UV_OV_OT} && intPriOverTemp |-> ##2 !systemReset_n;
    endproperty
    a_rst_temp: assert property (p_rst_temp) else $error("no temp reset");
    // an input outside the mask must never pull reset low
    property p_no_cause; !cond && !$past(cond) && systemReset_n |=> systemReset_n; endproperty
    a_no_cause: assert property (p_no_cause) else $error("unselected reset");
    property p_rd_sel; regRdEn && regAddr == OFS_OT_SRC_SEL |=> regRdData == $past(selReg);
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("bad select readback");
    property p_quiet; quiet && $past(quiet) && systemReset_n |=> systemReset_n; endproperty
    a_quiet: assert property (p_quiet) else $error("reset without cause");
    property p_hold; $fell(cond) |=> (!systemReset_n)[*8]; endproperty
    a_hold: assert property (p_hold) else $error("reset hold too short");

    c_clear: cover property (wrClr && !diode);
    c_cond: cover property (cond);
    c_hold: cover property ($fell(cond));
endmodule : rol_output_logic_chk

bind rol_output_logic rol_output_logic_chk i_rol_output_logic_chk (.*);

// ==== sim/rol_reset_sink.sv ====
/* far side of the reset output: a host that logs each low run of reset.
   assumes reset is sampled on the rising clock edge. */
module rol_reset_sink (
    input  wire logic    clk,
    input  wire logic    systemReset_n,
    output var int unsigned lowLen
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // low run logger
    // ====================
    int unsigned run = 0;

    // a run is logged once reset is seen high; the host never drives it back
    always @(posedge clk) begin
        if (!systemReset_n) begin
            run <= run + 1;
        end else begin
            if (run != 0) lowLen <= run;
            run <= 0;
        end
    end
endmodule : rol_reset_sink

// ==== sim/tb_top.sv ====
/* bench for the output logic: registers, alarm latch, reset modes, timeouts.
   assumes shortened timeouts; the boot count keeps its full length. */
module tb_top import rol_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // stimulus and design
    // ====================
    localparam int unsigned TO [8] = '{TOUT0_CYC, 20, 24, 28, 32, 36, 40, 44};
    localparam logic [16:0] CAUSE [4] = '{17'h00004, 17'h00400, 17'h10000, 17'h00008};
    localparam logic [7:0]  HIT [4] = '{8'h3A, 8'h2C, 8'h30, 8'h00};
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wrEn = 1'b0;
    logic        rdEn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdat = 8'h00;
    logic [7:0]  rdat;
    logic [7:0]  mask = 8'h00;
    logic [7:0]  uv = 8'h00;
    logic [7:0]  ov = 8'h00;
    logic [2:0]  temp = 3'h0;
    logic [3:0]  diode = 4'h0;
    logic        alarm_n;
    logic        rst_n;
    int unsigned lowLen;
    int          failures = 0;
    int          cmp_count = 0;
    int          n;
    int unsigned base;

    always #25 clk = ~clk;

    // short counts keep a full sweep of the timeout codes quick
    rol_output_logic #(.TOUT1_CYCLES(rol_cnt_t'(TO[1])), .TOUT2_CYCLES(rol_cnt_t'(TO[2])),
        .TOUT3_CYCLES(rol_cnt_t'(TO[3])), .TOUT4_CYCLES(rol_cnt_t'(TO[4])),
        .TOUT5_CYCLES(rol_cnt_t'(TO[5])), .TOUT6_CYCLES(rol_cnt_t'(TO[6])),
        .TOUT7_CYCLES(rol_cnt_t'(TO[7]))
    ) i_rol_output_logic (.clk(clk), .rst_b(rst_b), .regWrEn(wrEn), .regRdEn(rdEn),
        .regAddr(addr), .regWrData(wdat), .regRdData(rdat), .reset_input_select_mask(mask),
        .priUnderVolt(uv), .priOverVolt(ov), .intPriOverTemp(temp[0]),
        .rem1PriOverTemp(temp[1]), .rem2PriOverTemp(temp[2]), .rem1DiodeShort(diode[0]),
        .rem1DiodeOpen(diode[1]), .rem2DiodeShort(diode[2]), .rem2DiodeOpen(diode[3]),
        .overtemp_alarm_n(alarm_n), .systemReset_n(rst_n));
    rol_reset_sink i_rol_reset_sink (.clk(clk), .systemReset_n(rst_n), .lowLen(lowLen));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wrEn = 1'b1;
        addr = a;
        wdat = d;
        @(negedge clk);
        wrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rdEn = 1'b1;
        addr = a;
        @(negedge clk);
        rdEn = 1'b0;
        @(negedge clk);
        check($sformatf("reg %0h", a), e, rdat);
    endtask : rd
    // bounded wait for release, then one more edge so the sink logs the run
    task automatic wait_rel();
        n = 0;
        while (rst_n !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        check("release", 1'b1, rst_n);
    endtask : wait_rel
    task automatic pulse(input logic [16:0] v, input int p);
        {temp[0], ov, uv} = v;
        repeat (p) @(negedge clk);
        {temp[0], ov, uv} = 17'h00000;
        @(negedge clk);
    endtask : pulse
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic t_boot();
        check("boot low", 1'b0, rst_n);
        wait_rel();
        check("boot span", 1'b1, n inside {[495:505]});
        $display("t_boot done");
    endtask : t_boot
    task automatic t_regs();
        rd(OFS_OT_SRC_SEL, 8'h00);
        rd(OFS_RST_CFG, 8'h00);
        wr(OFS_OT_SRC_SEL, 8'hFF);
        rd(OFS_OT_SRC_SEL, 8'h7F);
        wr(OFS_RST_CFG, 8'hFF);
        rd(OFS_RST_CFG, 8'h3F);
        wr(8'h33, 8'hFF);
        rd(8'h33, 8'h00);
        wr(OFS_OT_SRC_SEL, 8'h00);
        @(negedge clk);
        wr(OFS_RST_CFG, 8'h00);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_alarm();
        for (int b = 0; b < 4; b++) begin
            wr(OFS_OT_SRC_SEL, 8'h08 << b);
            diode = 4'h1 << b;
            @(negedge clk);
            diode = 4'h0;
            repeat (3) @(negedge clk);
            check("latched", 1'b0, alarm_n);
            rd(OFS_DIODE_LATCH, 8'h01 << b);
            diode = 4'h1 << b;
            wr(OFS_DIODE_LATCH, 8'hA5);
            diode = 4'h0;
            @(negedge clk);
            check("set wins", 1'b0, alarm_n);
            wr(OFS_DIODE_LATCH, 8'h00);
            @(negedge clk);
            check("cleared", 1'b1, alarm_n);
        end
        // primary thresholds follow their flags and must not latch
        wr(OFS_OT_SRC_SEL, 8'h07);
        for (int t = 0; t < 3; t++) begin
            temp = 3'h1 << t;
            repeat (2) @(negedge clk);
            check("live", 1'b0, alarm_n);
            temp = 3'h0;
            repeat (2) @(negedge clk);
            check("unlatched", 1'b1, alarm_n);
        end
        wr(OFS_OT_SRC_SEL, 8'h00);
        diode = 4'hF;
        @(negedge clk);
        diode = 4'h0;
        @(negedge clk);
        check("disabled", 1'b1, alarm_n);
        $display("t_alarm done");
    endtask : t_alarm
    // each mode against undervolt, overvolt, internal overtemp and an unmasked input
    task automatic t_modes();
        mask = 8'h04;
        for (int m = 0; m < 8; m++) begin
            wr(OFS_RST_CFG, 8'h08 | 8'(m));
            for (int s = 0; s < 4; s++) begin
                pulse(CAUSE[s], 2);
                if (HIT[s][m]) begin
                    check("mode", 1'b0, rst_n);
                end else begin
                    check("mode idle", 1'b1, rst_n);
                end
                wait_rel();
            end
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_tout();
        mask = 8'h80;
        // a three-cycle cause: the low run is the timeout plus two cycles
        base = 2;
        for (int k = 0; k < 8; k++) begin
            wr(OFS_RST_CFG, 8'(k << 3) | 8'h01);
            pulse(17'h00080, 3);
            wait_rel();
            check("timeout", TO[k] + base, lowLen);
        end
        wr(OFS_RST_CFG, 8'h09);
        pulse(17'h00080, 3);
        repeat (5) @(negedge clk);
        pulse(17'h00080, 3);
        wait_rel();
        check("restart", base + TO[1] + 9, lowLen);
        $display("t_tout done");
    endtask : t_tout

    initial begin
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        t_boot();
        t_regs();
        t_alarm();
        t_modes();
        t_tout();
        test_done();
    end
    // watchdog: the sequence needs well under a tenth of this span
    initial begin
        #2000000;
        failures++;
        test_done();
    end
endmodule : tb_top
